// file: dmlc_decoder.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// (RULE1) page set selects access page only
// (RULE2) top bit zero loads column address
// (RULE3) column increment saturates at 50H
// (RULE4) status byte: busy, direction, off, reset
// (RULE5) busy during reset; instructions refused
// (RULE6) direction status one means forward
// (RULE7) off status inverts display command bit
// (RULE8) reset status high while initializing
// (RULE9) data write stores byte, increments column
// (RULE10) data read returns byte, increments column
// (RULE11) host discards first read after column set; the testbench host checks that first read as data
// (RULE12) direction command low bit selects order
// (RULE13) static drive forces all dots on
// (RULE14) duty bit selects 1/16 or 1/32
// (RULE15) modify mode: reads keep column fixed
// (RULE16) end command restores saved column
// (RULE17) host avoids column set in modify mode
// (RULE18) reset command: line first, page three
// (RULE19) display off plus static means power save
// (RULE20) display on or static off exits
// (RULE21) power save output cuts bias current
// (RULE22) host uses reset pin at power on
// (RULE23) display on/off command bit
// (RULE24) start line command loads five bits
// (RULE25) instruction decode on write, others ignored
module dmlc_decoder
   import dmlc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic cmd_data_select_in,
   input wire logic rd_n_in,
   input wire logic wr_n_in,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe_out,
   output logic [4:0] start_line_out,
   output logic [1:0] page_out,
   output logic [6:0] column_out,
   output logic seg_reverse_out,
   output logic static_drive_out,
   output logic display_on_out,
   output logic duty_32_out,
   output logic power_save_out,
   output logic busy_out,
   output logic [7:0] wr_data_out,
   output logic wr_valid_out,
   input wire logic wr_ready_in
);
   typedef enum logic [2:0]
   {
      ST_RESET = 3'h1,
      ST_IDLE = 3'h2,
      ST_HOLD = 3'h4
   } dmlc_state_e;
   typedef struct packed {
      dmlc_state_e state;
      logic [DMLC_CNT_W-1:0] cnt;
      logic [2:0] a0_s1;
      logic [2:0] a0_s2;
      logic [2:0] prev;
      logic [7:0] db_s1;
      logic [7:0] db_s2;
      logic [4:0] line;
      logic [1:0] page;
      logic [6:0] col;
      logic [6:0] col_save;
      logic rmw;
      logic seg_rev;
      logic stat;
      logic disp_on;
      logic duty32;
      logic rst_flag;
      logic [7:0] dout;
      logic oe;
   } dmlc_dec_s;
   dmlc_dec_s st_r;
   dmlc_dec_s st_nxt;
   logic fifo_in_valid;
   logic fifo_in_ready;
   // each queue entry carries its own ram address beside the byte
   logic [DMLC_DATA_W+DMLC_RAM_AW-1:0] fifo_in_data;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [DMLC_DATA_W+DMLC_RAM_AW-1:0] fifo_out_data;
   logic ram_we;
   logic [DMLC_RAM_AW-1:0] ram_wa;
   logic [DMLC_RAM_AW-1:0] ram_ra;
   logic [7:0] ram_rd_r;
   logic [7:0] ram [DMLC_RAM_WORDS];
   logic wr_strobe;
   logic rd_strobe;
   logic sel;
   logic [7:0] cmd;
   logic [7:0] status;
   logic [6:0] col_inc;
   function automatic logic [6:0] dmlc_inc(input logic [6:0] c);
      dmlc_inc = (c >= DMLC_COL_MAX) ? c : 7'(c + 7'h01); // RULE3
   endfunction : dmlc_inc
   // pins are asynchronous to clk_sys_in, so two stages before use
   assign sel = st_r.a0_s2[0];
   assign cmd = st_r.db_s2;
   // strobes act on the leading edge of the active-low pulse
   assign wr_strobe = st_r.a0_s2[2] && !st_r.prev[2];
   assign rd_strobe = st_r.a0_s2[1] && !st_r.prev[1];
   assign col_inc = dmlc_inc(st_r.col);
   assign busy_out = (st_r.state != ST_IDLE) || !fifo_in_ready; // RULE5
   assign status = {busy_out, !st_r.seg_rev, !st_r.disp_on, st_r.rst_flag, 4'h0}; // RULE4 RULE6 RULE7 RULE8
   assign power_save_out = !st_r.disp_on && st_r.stat; // RULE19 RULE21
   // data bytes queue toward the ram port; a full queue holds the decoder busy
   assign fifo_in_valid = (st_r.state == ST_IDLE) && wr_strobe && sel;
   assign fifo_in_data = {st_r.page, st_r.col, cmd};
   // a stalled ram port keeps the head in the queue
   assign fifo_out_ready = wr_ready_in;
   assign wr_valid_out = fifo_out_valid;
   assign wr_data_out = fifo_out_data[DMLC_DATA_W-1:0];
   assign ram_we = fifo_out_valid && wr_ready_in;
   assign ram_wa = fifo_out_data[DMLC_DATA_W+DMLC_RAM_AW-1:DMLC_DATA_W];
   assign ram_ra = {st_r.page, st_r.col};
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.a0_s1 = {!wr_n_in, !rd_n_in, cmd_data_select_in};
      st_nxt.a0_s2 = st_r.a0_s1;
      st_nxt.prev = st_r.a0_s2;
      st_nxt.db_s1 = data_in;
      st_nxt.db_s2 = st_r.db_s1;
      st_nxt.oe = st_r.a0_s2[1];
      if (st_r.a0_s2[1] && !st_r.prev[1])
      begin
         st_nxt.dout = sel ? ram_rd_r : status;
      end
      unique case (st_r.state)
         ST_RESET:
         begin
            st_nxt.rst_flag = 1'b1; // RULE8
            if (st_r.cnt == DMLC_CNT_W'(DMLC_RESET_CYC - 1))
            begin
               st_nxt.state = ST_IDLE;
               st_nxt.rst_flag = 1'b0;
               st_nxt.cnt = '0;
            end
            else
            begin
               st_nxt.cnt = st_r.cnt + 1'b1;
            end
         end
         ST_HOLD:
         begin
            if (fifo_in_ready)
            begin
               st_nxt.state = ST_IDLE;
            end
         end
         ST_IDLE:
         begin
            if (wr_strobe && !sel) // RULE25
            begin
               if (!cmd[7])
               begin
                  st_nxt.col = cmd[6:0]; // RULE2
               end
               else if ((cmd & DMLC_PAGE_MASK) == DMLC_PAGE_CODE)
               begin
                  st_nxt.page = cmd[1:0]; // RULE1
               end
               else if ((cmd & DMLC_LINE_MASK) == DMLC_LINE_CODE)
               begin
                  st_nxt.line = cmd[4:0]; // RULE24
               end
               else
               begin
                  unique case (cmd)
                     DMLC_CMD_DISP_OFF: st_nxt.disp_on = 1'b0; // RULE23
                     DMLC_CMD_DISP_ON: st_nxt.disp_on = 1'b1; // RULE23 RULE20
                     DMLC_CMD_SEG_FWD: st_nxt.seg_rev = 1'b0; // RULE12
                     DMLC_CMD_SEG_REV: st_nxt.seg_rev = 1'b1; // RULE12
                     DMLC_CMD_STATIC_OFF: st_nxt.stat = 1'b0; // RULE13 RULE20
                     DMLC_CMD_STATIC_ON: st_nxt.stat = 1'b1; // RULE13
                     DMLC_CMD_DUTY_16: st_nxt.duty32 = 1'b0; // RULE14
                     DMLC_CMD_DUTY_32: st_nxt.duty32 = 1'b1; // RULE14
                     DMLC_CMD_RMW:
                     begin
                        st_nxt.rmw = 1'b1; // RULE15
                        st_nxt.col_save = st_r.col;
                     end
                     DMLC_CMD_END:
                     begin
                        if (st_r.rmw)
                        begin
                           st_nxt.col = st_r.col_save; // RULE16
                        end
                        st_nxt.rmw = 1'b0; // RULE16
                     end
                     DMLC_CMD_RESET:
                     begin
                        st_nxt.line = DMLC_LINE_RESET; // RULE18
                        st_nxt.page = DMLC_PAGE_RESET; // RULE18
                        st_nxt.state = ST_RESET; // RULE8
                        st_nxt.cnt = '0;
                     end
                     default:
                     begin
                     end
                  endcase
               end
            end
            else if (wr_strobe && sel)
            begin
               st_nxt.col = col_inc; // RULE9 RULE3
               if (!fifo_in_ready)
               begin
                  st_nxt.state = ST_HOLD;
               end
            end
            else if (rd_strobe && sel && !st_r.rmw)
            begin
               st_nxt.col = col_inc; // RULE10 RULE15
            end
         end
         default:
         begin
            st_nxt.state = ST_RESET;
         end
      endcase
   end
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         st_r <= '0;
         st_r.state <= ST_RESET;
         st_r.a0_s1 <= 3'h1;
         st_r.a0_s2 <= 3'h1;
         st_r.prev <= 3'h1;
         st_r.line <= DMLC_LINE_RESET;
         st_r.page <= DMLC_PAGE_RESET;
         st_r.col <= DMLC_COL_RESET;
         st_r.rst_flag <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end
   always_ff @(posedge clk_sys_in)
   begin
      if (ram_we)
      begin
         ram[ram_wa] <= fifo_out_data[DMLC_DATA_W-1:0]; // RULE9
      end
      ram_rd_r <= ram[ram_ra]; // RULE10
   end
   dmlc_fifo #(.WIDTH(DMLC_DATA_W + DMLC_RAM_AW), .DEPTH(DMLC_FIFO_DEPTH)) u_fifo
   (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .in_valid_in(fifo_in_valid),
      .in_ready_out(fifo_in_ready),
      .in_data_in(fifo_in_data),
      .out_valid_out(fifo_out_valid),
      .out_ready_in(fifo_out_ready),
      .out_data_out(fifo_out_data)
   );
   assign data_out = st_r.dout;
   assign data_oe_out = st_r.oe;
   assign start_line_out = st_r.line;
   assign page_out = st_r.page;
   assign column_out = st_r.col;
   assign seg_reverse_out = st_r.seg_rev;
   assign static_drive_out = st_r.stat;
   assign display_on_out = st_r.disp_on;
   assign duty_32_out = st_r.duty32;
endmodule : dmlc_decoder
`default_nettype wire

// file: dmlc_pkg.sv
package dmlc_pkg;
   localparam int DMLC_DATA_W = 8;
   localparam int DMLC_COL_W = 7;
   localparam int DMLC_PAGE_W = 2;
   localparam int DMLC_LINE_W = 5;
   localparam int DMLC_FIFO_DEPTH = 16;
   localparam int DMLC_RAM_WORDS = 512;
   localparam int DMLC_RAM_AW = 9;
   // column increment saturates here
   localparam logic [6:0] DMLC_COL_MAX = 7'h50;
   localparam logic [1:0] DMLC_PAGE_RESET = 2'h3;
   localparam logic [4:0] DMLC_LINE_RESET = 5'h00;
   localparam logic [6:0] DMLC_COL_RESET = 7'h00;
   // command codes
   localparam logic [7:0] DMLC_CMD_DISP_OFF = 8'hae;
   localparam logic [7:0] DMLC_CMD_DISP_ON = 8'haf;
   localparam logic [7:0] DMLC_CMD_SEG_FWD = 8'ha0;
   localparam logic [7:0] DMLC_CMD_SEG_REV = 8'ha1;
   localparam logic [7:0] DMLC_CMD_STATIC_OFF = 8'ha4;
   localparam logic [7:0] DMLC_CMD_STATIC_ON = 8'ha5;
   localparam logic [7:0] DMLC_CMD_DUTY_16 = 8'ha8;
   localparam logic [7:0] DMLC_CMD_DUTY_32 = 8'ha9;
   localparam logic [7:0] DMLC_CMD_RMW = 8'he0;
   localparam logic [7:0] DMLC_CMD_END = 8'hee;
   localparam logic [7:0] DMLC_CMD_RESET = 8'he2;
   localparam logic [7:0] DMLC_PAGE_MASK = 8'hfc;
   localparam logic [7:0] DMLC_PAGE_CODE = 8'hb8;
   localparam logic [7:0] DMLC_LINE_MASK = 8'he0;
   localparam logic [7:0] DMLC_LINE_CODE = 8'hc0;
   // status bit positions
   localparam int DMLC_ST_BUSY = 7;
   localparam int DMLC_ST_SEG = 6;
   localparam int DMLC_ST_OFF = 5;
   localparam int DMLC_ST_RST = 4;
   // busy / reset-cycle timing
   localparam int DMLC_CLK_MHZ = 25;
   localparam int DMLC_RESET_NS = 1000;
   localparam int DMLC_RESET_CYC = (DMLC_RESET_NS * DMLC_CLK_MHZ + 999) / 1000;
   localparam int DMLC_CNT_W = 6;
endpackage : dmlc_pkg

// file: dmlc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module dmlc_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } dmlc_fifo_s;
   dmlc_fifo_s st_r;
   dmlc_fifo_s st_nxt;
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic full;
   logic empty;
   logic push;
   logic pop;
   assign full = (st_r.wp[AW] != st_r.rp[AW]) && (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]);
   assign empty = st_r.wp == st_r.rp;
   assign in_ready_out = !full;
   assign out_valid_out = !empty;
   assign push = in_valid_in && !full;
   assign pop = out_ready_in && !empty;
   assign out_data_out = mem_r[st_r.rp[AW-1:0]];
   always_comb
   begin
      st_nxt = st_r;
      if (push)
      begin
         st_nxt.wp = st_r.wp + 1'b1;
      end
      if (pop)
      begin
         st_nxt.rp = st_r.rp + 1'b1;
      end
   end
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
      if (push)
      begin
         mem_r[st_r.wp[AW-1:0]] <= in_data_in;
      end
   end
endmodule : dmlc_fifo
`default_nettype wire

// file: dmlc_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dmlc_sva
   import dmlc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic cmd_data_select_in,
   input wire logic rd_n_in,
   input wire logic data_oe_out,
   input wire logic [4:0] start_line_out,
   input wire logic [1:0] page_out,
   input wire logic [6:0] column_out,
   input wire logic static_drive_out,
   input wire logic display_on_out,
   input wire logic power_save_out,
   input wire logic busy_out,
   input wire logic [7:0] wr_data_out,
   input wire logic wr_valid_out,
   input wire logic wr_ready_in
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);
   sequence s_rd_low;
      !rd_n_in [*5];
   endsequence
   sequence s_rd_high;
      rd_n_in [*5];
   endsequence
   // no command can land while select has stayed high this long
   sequence s_data_phase;
      cmd_data_select_in [*8];
   endsequence
   chk_power_save: assert property (power_save_out == (!display_on_out && static_drive_out))
      else $error("power save flag wrong");
   chk_col_limit: assert property (column_out <= 7'h50)
      else $error("column past limit");
   chk_col_step: assert property (s_data_phase |-> (column_out == $past(column_out)) || (column_out == $past(column_out) + 7'h01))
      else $error("column jumped on data access");
   chk_page_hold: assert property (s_data_phase |-> $stable(page_out) && $stable(start_line_out))
      else $error("page moved on data access");
   chk_oe_on: assert property (s_rd_low |-> data_oe_out)
      else $error("bus not driven during read");
   chk_oe_off: assert property (s_rd_high |-> !data_oe_out)
      else $error("bus driven outside read");
   chk_busy_reset: assert property ($fell(rst_in) |-> busy_out [*8])
      else $error("busy low in reset cycle");
   chk_busy_ends: assert property ($fell(rst_in) |-> ##[1:40] !busy_out)
      else $error("reset cycle never ends");
   chk_reset_state: assert property ($fell(rst_in) |-> page_out == 2'h3 && column_out == 7'h00 && start_line_out == 5'h00 && !display_on_out)
      else $error("reset values wrong");
   chk_fifo_hold: assert property (wr_valid_out && !wr_ready_in |=> wr_valid_out && $stable(wr_data_out))
      else $error("fifo head lost while stalled");
endmodule : dmlc_sva
bind dmlc_decoder dmlc_sva u_sva (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
   .cmd_data_select_in(cmd_data_select_in), .rd_n_in(rd_n_in), .data_oe_out(data_oe_out),
   .start_line_out(start_line_out), .page_out(page_out), .column_out(column_out),
   .static_drive_out(static_drive_out), .display_on_out(display_on_out),
   .power_save_out(power_save_out), .busy_out(busy_out), .wr_data_out(wr_data_out),
   .wr_valid_out(wr_valid_out), .wr_ready_in(wr_ready_in));
`default_nettype wire

// file: dmlc_host.sv
`timescale 1ns/1ps
`default_nettype none
module dmlc_host
(
   input wire logic clk_sys_in,
   input wire logic busy_in,
   input wire logic [7:0] bus_in,
   output logic cds_out,
   output logic rd_n_out,
   output logic wr_n_out,
   output logic [7:0] bus_out,
   output logic ready_out
);
   initial
   begin
      cds_out = 1'b0;
      rd_n_out = 1'b1;
      wr_n_out = 1'b1;
      bus_out = 8'h00;
      ready_out = 1'b1;
   end
   // bounded so a stuck busy cannot hang the host
   task automatic idle();
      int n;
      n = 0;
      while (busy_in === 1'b1 && n < 400)
      begin
         @(negedge clk_sys_in);
         n++;
      end
   endtask : idle
   task automatic xfer(input logic cds, input logic rd, input logic [7:0] d,
                       output logic [7:0] q);
      idle();
      cds_out = cds;
      bus_out = d;
      if (rd)
         rd_n_out = 1'b0;
      else
         wr_n_out = 1'b0;
      repeat (6) @(negedge clk_sys_in);
      q = bus_in;
      rd_n_out = 1'b1;
      wr_n_out = 1'b1;
      // released bus must not keep showing the last byte
      bus_out = ~d;
      repeat (7) @(negedge clk_sys_in);
   endtask : xfer
endmodule : dmlc_host
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dmlc_pkg::*;
   logic clk_sys_in, rst_in, cds, rd_n, wr_n, oe, rev, stat, don, d32, ps, busy, wv, wrdy;
   logic [7:0] din, dout, wdata, q, lf, first;
   logic [4:0] line;
   logic [1:0] page, pg;
   logic [6:0] col, c;
   logic [7:0] mem [512];
   int failures, check_count;
   always #20 clk_sys_in = ~clk_sys_in;
   dmlc_decoder DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cmd_data_select_in(cds),
      .rd_n_in(rd_n), .wr_n_in(wr_n), .data_in(din), .data_out(dout), .data_oe_out(oe),
      .start_line_out(line), .page_out(page), .column_out(col), .seg_reverse_out(rev),
      .static_drive_out(stat), .display_on_out(don), .duty_32_out(d32),
      .power_save_out(ps), .busy_out(busy), .wr_data_out(wdata), .wr_valid_out(wv),
      .wr_ready_in(wrdy));
   dmlc_host host (.clk_sys_in(clk_sys_in), .busy_in(busy), .bus_in(dout), .cds_out(cds),
      .rd_n_out(rd_n), .wr_n_out(wr_n), .bus_out(din), .ready_out(wrdy));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   function automatic logic [7:0] st_exp(input logic r, input logic on);
      return {1'b0, ~r, ~on, 5'h00};
   endfunction : st_exp
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic cmd(input logic [7:0] v);
      host.xfer(1'b0, 1'b0, v, q);
   endtask : cmd
   task automatic wrd(input logic [7:0] v);
      host.xfer(1'b1, 1'b0, v, q);
   endtask : wrd
   task automatic rdx(input logic s);
      host.xfer(s, 1'b1, 8'h00, q);
   endtask : rdx
   task automatic summarize();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   initial
   begin
      repeat (20000) @(posedge clk_sys_in);
      failures++;
      summarize();
   end
   initial
   begin
      clk_sys_in = 1'b0;
      rst_in = 1'b1;
      lf = 8'h0b;
      repeat (12) @(negedge clk_sys_in);
      rst_in = 1'b0;
      @(negedge clk_sys_in);
      chk("busy", 8'h01, {7'h00, busy});
      rdx(1'b0);
      chk("status", st_exp(1'b0, 1'b0), q);
      for (int i = 0; i < 10; i++)
      begin
         lf = lfsr(lf);
         cmd(DMLC_CMD_SEG_FWD | {7'h00, lf[0]});
         cmd(DMLC_CMD_STATIC_OFF | {7'h00, lf[1]});
         cmd(DMLC_CMD_DUTY_16 | {7'h00, lf[2]});
         cmd(DMLC_CMD_DISP_OFF | {7'h00, lf[3]});
         cmd(8'hff);
         chk("mode", {4'h0, lf[3:0]}, {4'h0, don, d32, stat, rev});
         chk("psave", {7'h00, !lf[3] && lf[1]}, {7'h00, ps});
         rdx(1'b0);
         chk("status", st_exp(lf[0], lf[3]), q);
      end
      cmd(DMLC_CMD_DISP_OFF);
      cmd(DMLC_CMD_STATIC_ON);
      chk("psave", 8'h01, {7'h00, ps});
      cmd(DMLC_CMD_STATIC_OFF);
      chk("psave", 8'h00, {7'h00, ps});
      cmd(DMLC_CMD_STATIC_ON);
      cmd(DMLC_CMD_DISP_ON);
      chk("psave", 8'h00, {7'h00, ps});
      lf = lfsr(lf);
      cmd(DMLC_LINE_CODE | {3'h0, lf[4:0]});
      chk("line", {3'h0, lf[4:0]}, {3'h0, line});
      pg = lf[6:5];
      cmd(DMLC_PAGE_CODE | {6'h00, pg});
      chk("page", {6'h00, pg}, {6'h00, page});
      chk("line", {3'h0, lf[4:0]}, {3'h0, line});
      cmd(8'h4e);
      repeat (3) wrd(8'h5a);
      chk("col", 8'h50, {1'b0, col});
      chk("page", {6'h00, pg}, {6'h00, page});
      c = {1'b0, lf[5:0]};
      cmd({1'b0, c});
      chk("col", {1'b0, c}, {1'b0, col});
      host.ready_out = 1'b0;
      for (int i = 0; i < 16; i++)
      begin
         lf = lfsr(lf);
         if (i == 0)
            first = lf;
         mem[{pg, c + 7'(i)}] = lf;
         wrd(lf);
         chk("col", {1'b0, c + 7'(i + 1)}, {1'b0, col});
      end
      chk("full", 8'h03, {6'h00, busy, wv});
      chk("head", first, wdata);
      host.ready_out = 1'b1;
      host.idle();
      chk("busy", 8'h00, {7'h00, busy});
      cmd({1'b0, c});
      rdx(1'b1);
      chk("rdata", mem[{pg, c}], q);
      for (int i = 1; i < 16; i++)
      begin
         rdx(1'b1);
         chk("rdata", mem[{pg, c + 7'(i)}], q);
      end
      chk("col", {1'b0, c + 7'd16}, {1'b0, col});
      cmd({1'b0, c});
      cmd(DMLC_CMD_RMW);
      rdx(1'b1);
      rdx(1'b1);
      chk("col", {1'b0, c}, {1'b0, col});
      lf = lfsr(lf);
      mem[{pg, c}] = lf;
      wrd(lf);
      chk("col", {1'b0, c + 7'd1}, {1'b0, col});
      cmd(DMLC_CMD_END);
      chk("col", {1'b0, c}, {1'b0, col});
      cmd(DMLC_CMD_RESET);
      chk("busy", 8'h01, {7'h00, busy});
      host.idle();
      chk("page", 8'h03, {6'h00, page});
      chk("line", 8'h00, {3'h0, line});
      cmd(DMLC_PAGE_CODE | {6'h00, pg});
      cmd({1'b0, c});
      rdx(1'b1);
      chk("rdata", mem[{pg, c}], q);
      rdx(1'b1);
      chk("rdata", mem[{pg, c + 7'd1}], q);
      summarize();
   end
endmodule : testbench
`default_nettype wire
